/* File: usc_consts.svh */
// Register offsets, field positions, reset values and timing counts of the serial port block.
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH
`define USC_ADDR_RXCTL 8'h18
`define USC_ADDR_TXCTL 8'h98
`define USC_ADDR_TXBUF 8'h19
`define USC_ADDR_RXBUF 8'h1a
`define USC_ADDR_BAUD 8'h99
`define USC_ADDR_PORTDIR 8'h87
`define USC_ADDR_INTSTAT 8'h0c
`define USC_ADDR_INTMASK 8'h8c
`define USC_TX_CLOCK_SOURCE_SELECT 7
`define USC_TX_NINE 6
`define USC_TX_EN 5
`define USC_TX_SYNC 4
`define USC_TX_HIGH_SPEED_BAUD_SELECT 2
`define USC_TX_EMPTY 1
`define USC_TX_BIT9 0
`define USC_RX_SERIAL_PORT_ENABLE 7
`define USC_RX_NINE 6
`define USC_RX_SINGLE_RECEIVE_ENABLE 5
`define USC_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define USC_RX_FRAMING_ERROR_FLAG 2
`define USC_RX_OVERRUN_ERROR_FLAG 1
`define USC_RX_BIT9 0
`define USC_DIR_TXCK 6
`define USC_DIR_DT 7
`define USC_TX_WMASK 8'hf5
`define USC_RX_WMASK 8'hf0
`define USC_TXCTL_RST 8'h00
`define USC_RXCTL_RST 8'h00
`define USC_PORTDIR_RST 8'hff
`define USC_BAUD_RST 8'h00
`define USC_OVS_LO_M1 6'd63
`define USC_OVS_HI_M1 6'd15
`define USC_OVS_SYNC_M1 6'd3
`define USC_HALF_LO_M1 6'd31
`define USC_HALF_HI_M1 6'd7
`define USC_INT_RXCHAR 0
`define USC_INT_TXLOAD 1
`define USC_INT_FRAMING_ERROR_FLAG 2
`define USC_INT_OVERRUN_ERROR_FLAG 3
`endif

/* File: usc_pkg.sv */
// Types shared by the serial port block.
package usc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usc_bus_req_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } usc_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b100
  } usc_rx_st_t;
endpackage : usc_pkg

/* File: usc_sync2.sv */
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/10ps
module usc_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk, // Block clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [W-1:0] d, // Asynchronous inputs.
  output logic [W-1:0] q // Synchronised outputs.
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Reset to the idle level of the pulled-up pins, so no false edge follows reset.
      meta_ff <= '1;
      q_ff <= '1;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule : usc_sync2

/* File: usc_serial_port.sv */
// Serial port mode, pin ownership, shifters and status control.
`timescale 1ns/10ps
`include "usc_consts.svh"
module usc_serial_port (
  input wire logic ref_clk, // Block clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire usc_pkg::usc_bus_req_t bus_req, // Register request.
  output logic [7:0] rdata, // Read data, cycle after the read strobe.
  output logic irq, // Level interrupt.
  input wire logic transmit_clock_pin_i, // Transmit or clock pin level.
  output logic transmit_clock_pin_o, // Transmit or clock pin drive value.
  output logic transmit_clock_pin_oe, // Transmit or clock pin drive enable.
  input wire logic receive_data_pin_i, // Receive or data pin level.
  output logic receive_data_pin_o, // Receive or data pin drive value.
  output logic receive_data_pin_oe // Receive or data pin drive enable.
);
  import usc_pkg::*;
  logic [7:0] txctl_ff, rxctl_ff, dir_ff, baud_ff, brg_cnt_ff, txbuf_ff, rxbuf_ff, rdata_ff;
  logic [3:0] stat_ff, mask_ff, nxt_stat, ev;
  logic [1:0] pin_s;
  logic ck_d_ff, sclk_ff, hcnt_ff, tx_full_ff, rx_full_ff, rx_b9_ff, framing_error_flag_ff, overrun_error_flag_ff, irq_ff;
  logic txck_o_ff, txck_oe_ff, dt_o_ff, dt_oe_ff;
  usc_tx_st_t tx_st_ff;
  usc_rx_st_t rx_st_ff;
  logic [10:0] tx_sr_ff;
  logic [8:0] rx_sr_ff, rx_word;
  logic [3:0] tx_cnt_ff, rx_cnt_ff, nbits_tx, nbits_rx, tx_last, rx_last;
  logic [5:0] tx_ph_ff, rx_ph_ff, ovs_m1, half_m1;
  logic wr_txctl, wr_rxctl, wr_txbuf, rd_rxbuf, wr_stat;
  logic sync, clock_source_select, pins_on, tick, ck_s, dt_s, m_rise, m_fall, run_m, ck_rise, ck_fall;
  logic tx_busy, tx_load, tx_step, rx_run_a, rx_run_s, rx_run, rx_smp, rx_done, ovr;

  usc_sync2 #(.W(2)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({receive_data_pin_i, transmit_clock_pin_i}),
    .q(pin_s)
  );
  assign ck_s = pin_s[0];
  assign dt_s = pin_s[1];

  // Address decode and mode terms.
  assign wr_txctl = bus_req.wr && bus_req.addr == `USC_ADDR_TXCTL;
  assign wr_rxctl = bus_req.wr && bus_req.addr == `USC_ADDR_RXCTL;
  assign wr_txbuf = bus_req.wr && bus_req.addr == `USC_ADDR_TXBUF;
  assign wr_stat = bus_req.wr && bus_req.addr == `USC_ADDR_INTSTAT;
  assign rd_rxbuf = bus_req.rd && bus_req.addr == `USC_ADDR_RXBUF;
  assign sync = txctl_ff[`USC_TX_SYNC];
  assign clock_source_select = txctl_ff[`USC_TX_CLOCK_SOURCE_SELECT];
  assign pins_on = rxctl_ff[`USC_RX_SERIAL_PORT_ENABLE] && dir_ff[`USC_DIR_TXCK] && dir_ff[`USC_DIR_DT];
  assign ovs_m1 = sync ? `USC_OVS_SYNC_M1
                : (txctl_ff[`USC_TX_HIGH_SPEED_BAUD_SELECT] ? `USC_OVS_HI_M1 : `USC_OVS_LO_M1);
  assign half_m1 = txctl_ff[`USC_TX_HIGH_SPEED_BAUD_SELECT] ? `USC_HALF_HI_M1 : `USC_HALF_LO_M1;
  assign nbits_tx = txctl_ff[`USC_TX_NINE] ? 4'd9 : 4'd8;
  assign nbits_rx = rxctl_ff[`USC_RX_NINE] ? 4'd9 : 4'd8;
  assign tx_last = sync ? nbits_tx - 4'd1 : nbits_tx + 4'd1;
  assign rx_last = sync ? nbits_rx - 4'd1 : nbits_rx;

  // Control registers; hardware ends a single receive after one character.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txctl_ff <= `USC_TXCTL_RST;
      rxctl_ff <= `USC_RXCTL_RST;
      dir_ff <= `USC_PORTDIR_RST;
      baud_ff <= `USC_BAUD_RST;
      mask_ff <= 4'h0;
      txbuf_ff <= 8'h00;
    end else begin
      if (wr_txctl) txctl_ff <= bus_req.wdata & `USC_TX_WMASK;
      if (wr_rxctl) begin
        rxctl_ff <= bus_req.wdata & `USC_RX_WMASK;
      end else if (rx_done && sync) begin
        rxctl_ff[`USC_RX_SINGLE_RECEIVE_ENABLE] <= 1'b0;
      end
      if (bus_req.wr && bus_req.addr == `USC_ADDR_PORTDIR) dir_ff <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == `USC_ADDR_BAUD) baud_ff <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == `USC_ADDR_INTMASK) mask_ff <= bus_req.wdata[3:0];
      if (wr_txbuf) txbuf_ff <= bus_req.wdata;
    end
  end

  // Baud tick; a new divisor restarts the count at once.
  assign tick = brg_cnt_ff == baud_ff;
  always_ff @(posedge ref_clk) begin
    if (rst || (bus_req.wr && bus_req.addr == `USC_ADDR_BAUD) || tick) brg_cnt_ff <= 8'h00;
    else brg_cnt_ff <= brg_cnt_ff + 8'h01;
  end

  // master clock generation, four ticks a bit, low while idle.
  assign run_m = sync && clock_source_select && pins_on && (tx_busy || rx_st_ff == RX_DATA);
  assign m_rise = run_m && tick && hcnt_ff && !sclk_ff;
  assign m_fall = run_m && tick && hcnt_ff && sclk_ff;
  always_ff @(posedge ref_clk) begin
    if (rst || !run_m) begin
      sclk_ff <= 1'b0;
      hcnt_ff <= 1'b0;
    end else if (tick) begin
      hcnt_ff <= !hcnt_ff;
      if (hcnt_ff) sclk_ff <= !sclk_ff;
    end
  end
  // slave clock edges from the synchronised pin.
  always_ff @(posedge ref_clk) begin
    if (rst) ck_d_ff <= 1'b1;
    else ck_d_ff <= ck_s;
  end
  assign ck_rise = clock_source_select ? m_rise : (ck_s && !ck_d_ff);
  assign ck_fall = clock_source_select ? m_fall : (!ck_s && ck_d_ff);

  // transmit waits while synchronous receive is enabled.
  assign tx_busy = tx_st_ff == TX_SHIFT;
  assign tx_load = tx_st_ff == TX_IDLE && tx_full_ff && txctl_ff[`USC_TX_EN] && pins_on
                   && (!sync || (rx_st_ff == RX_IDLE && !rxctl_ff[`USC_RX_SINGLE_RECEIVE_ENABLE]
                   && !rxctl_ff[`USC_RX_CONTINUOUS_RECEIVE_ENABLE]));
  assign tx_step = sync ? ck_fall : (tick && tx_ph_ff == ovs_m1);
  always_ff @(posedge ref_clk) begin
    if (rst) tx_full_ff <= 1'b0;
    else if (wr_txbuf) tx_full_ff <= 1'b1;
    else if (tx_load) tx_full_ff <= 1'b0;
  end
  // transmit shifter, LSB first, start and stop framed when asynchronous.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_st_ff <= TX_IDLE;
      tx_sr_ff <= 11'h7ff;
      tx_cnt_ff <= 4'h0;
      tx_ph_ff <= 6'h00;
    end else begin
      case (tx_st_ff)
        TX_IDLE: begin
          if (tx_load) begin
            tx_st_ff <= TX_SHIFT;
            tx_cnt_ff <= 4'h0;
            tx_ph_ff <= 6'h00;
            if (sync) tx_sr_ff <= {2'b11, txctl_ff[`USC_TX_BIT9], txbuf_ff};
            else tx_sr_ff <= {1'b1, txctl_ff[`USC_TX_NINE] ? txctl_ff[`USC_TX_BIT9] : 1'b1,
                              txbuf_ff, 1'b0};
          end
        end
        TX_SHIFT: begin
          if (!txctl_ff[`USC_TX_EN] || !pins_on) begin
            tx_st_ff <= TX_IDLE;
          end else if (tx_step) begin
            if (tx_cnt_ff == tx_last) tx_st_ff <= TX_IDLE;
            tx_sr_ff <= {1'b1, tx_sr_ff[10:1]};
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            tx_ph_ff <= 6'h00;
          end else if (!sync && tick) begin
            tx_ph_ff <= tx_ph_ff + 6'h01;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // asynchronous receive runs regardless of the transmitter.
  assign rx_run_a = !sync && pins_on && rxctl_ff[`USC_RX_CONTINUOUS_RECEIVE_ENABLE] && !overrun_error_flag_ff;
  assign rx_run_s = sync && pins_on && !overrun_error_flag_ff
                    && (rxctl_ff[`USC_RX_SINGLE_RECEIVE_ENABLE] || rxctl_ff[`USC_RX_CONTINUOUS_RECEIVE_ENABLE]);
  assign rx_run = sync ? rx_run_s : rx_run_a;
  // synchronous bits are taken on the rising clock edge.
  assign rx_smp = sync ? ck_rise : (tick && rx_ph_ff == ovs_m1);
  assign rx_done = rx_st_ff == RX_DATA && rx_run && rx_smp && rx_cnt_ff == rx_last;
  assign rx_word = sync ? {dt_s, rx_sr_ff[8:1]} : rx_sr_ff;
  assign ovr = rx_done && rx_full_ff && !rd_rxbuf;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_st_ff <= RX_IDLE;
      rx_sr_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
      rx_ph_ff <= 6'h00;
    end else begin
      case (rx_st_ff)
        RX_IDLE: begin
          rx_cnt_ff <= 4'h0;
          rx_ph_ff <= 6'h00;
          if (rx_run_a && !dt_s) rx_st_ff <= RX_START;
          else if (rx_run_s && tx_st_ff == TX_IDLE) rx_st_ff <= RX_DATA;
        end
        RX_START: begin
          // Start bit is checked again at its middle.
          if (!rx_run_a) begin
            rx_st_ff <= RX_IDLE;
          end else if (tick) begin
            rx_ph_ff <= rx_ph_ff + 6'h01;
            if (rx_ph_ff == half_m1) begin
              rx_st_ff <= dt_s ? RX_IDLE : RX_DATA;
              rx_ph_ff <= 6'h00;
            end
          end
        end
        RX_DATA: begin
          if (!rx_run) begin
            rx_st_ff <= RX_IDLE;
          end else if (rx_smp) begin
            if (rx_cnt_ff == rx_last) rx_st_ff <= RX_IDLE;
            if (sync || rx_cnt_ff < nbits_rx) rx_sr_ff <= {dt_s, rx_sr_ff[8:1]};
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            rx_ph_ff <= 6'h00;
          end else if (!sync && tick) begin
            rx_ph_ff <= rx_ph_ff + 6'h01;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_full_ff <= 1'b0;
      rxbuf_ff <= 8'h00;
      rx_b9_ff <= 1'b0;
      framing_error_flag_ff <= 1'b0;
      overrun_error_flag_ff <= 1'b0;
    end else begin
      if (ovr) overrun_error_flag_ff <= 1'b1;
      else if (!rxctl_ff[`USC_RX_CONTINUOUS_RECEIVE_ENABLE]) overrun_error_flag_ff <= 1'b0;
      if (rx_done && !ovr) begin
        rx_full_ff <= 1'b1;
        rxbuf_ff <= rxctl_ff[`USC_RX_NINE] ? rx_word[7:0] : rx_word[8:1];
        rx_b9_ff <= rx_word[8];
        framing_error_flag_ff <= !sync && !dt_s;
      end else if (rd_rxbuf) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  // shift empty state raises no event; events are sticky and set wins over clear.
  assign ev[`USC_INT_RXCHAR] = rx_done && !ovr;
  assign ev[`USC_INT_TXLOAD] = tx_load;
  assign ev[`USC_INT_FRAMING_ERROR_FLAG] = rx_done && !ovr && !sync && !dt_s;
  assign ev[`USC_INT_OVERRUN_ERROR_FLAG] = ovr;
  assign nxt_stat = (stat_ff & ~(wr_stat ? bus_req.wdata[3:0] : 4'h0)) | ev;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & mask_ff);
    end
  end

  // read mux; status bits reflect live state, unmapped reads return zero.
  always_ff @(posedge ref_clk) begin
    if (rst || !bus_req.rd) begin
      rdata_ff <= 8'h00;
    end else begin
      case (bus_req.addr)
        `USC_ADDR_TXCTL: rdata_ff <= {txctl_ff[7:2], !tx_busy, txctl_ff[0]};
        `USC_ADDR_RXCTL: rdata_ff <= {rxctl_ff[7:4], 1'b0, framing_error_flag_ff, overrun_error_flag_ff, rx_b9_ff};
        `USC_ADDR_TXBUF: rdata_ff <= txbuf_ff;
        `USC_ADDR_RXBUF: rdata_ff <= rxbuf_ff;
        `USC_ADDR_BAUD: rdata_ff <= baud_ff;
        `USC_ADDR_PORTDIR: rdata_ff <= dir_ff;
        `USC_ADDR_INTSTAT: rdata_ff <= {4'h0, stat_ff};
        `USC_ADDR_INTMASK: rdata_ff <= {4'h0, mask_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // pin drivers, released whenever the port does not own the pins.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txck_o_ff <= 1'b1;
      txck_oe_ff <= 1'b0;
      dt_o_ff <= 1'b1;
      dt_oe_ff <= 1'b0;
    end else begin
      txck_o_ff <= sync ? sclk_ff : (tx_busy ? tx_sr_ff[0] : 1'b1);
      txck_oe_ff <= pins_on && (sync ? clock_source_select : txctl_ff[`USC_TX_EN]);
      dt_o_ff <= tx_sr_ff[0];
      dt_oe_ff <= pins_on && sync && tx_busy;
    end
  end
  assign rdata = rdata_ff;
  assign irq = irq_ff;
  assign transmit_clock_pin_o = txck_o_ff;
  assign transmit_clock_pin_oe = txck_oe_ff;
  assign receive_data_pin_o = dt_o_ff;
  assign receive_data_pin_oe = dt_oe_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence async_load_s;
    tx_load && !sync;
  endsequence
  pin_claim_a: assert property ((txck_oe_ff || dt_oe_ff) |-> $past(pins_on))
    else $error("Pin driven without port ownership.");
  duplex_rx_a: assert property ((rx_st_ff == RX_IDLE && rx_run_a && !dt_s) |=>
    rx_st_ff == RX_START) else $error("Async receive start lost.");
  half_duplex_a: assert property ((sync && $past(sync)) |->
    !(tx_busy && rx_st_ff == RX_DATA)) else $error("Both directions active in sync mode.");
  master_clk_a: assert property ((sync && clock_source_select && pins_on) |=> txck_oe_ff)
    else $error("Master clock not driven.");
  slave_edge_a: assert property ((sync && !clock_source_select && tx_busy && !(!ck_s && ck_d_ff)) |=>
    $stable(tx_sr_ff)) else $error("Slave shifted without a clock edge.");
  frame_start_a: assert property (async_load_s |=> tx_sr_ff[0] == 1'b0 ##1
    (!tx_busy || !tx_step || tx_sr_ff[0] == 1'b0)) else $error("Start bit missing.");
  mode_async_a: assert property ($past(!sync && txctl_ff[`USC_TX_EN] && pins_on) |->
    txck_oe_ff && !dt_oe_ff) else $error("Async mode pin use wrong.");
  baud_wrap_a: assert property ((!sync && tx_busy && txctl_ff[`USC_TX_EN] && pins_on
    && tick && tx_ph_ff == ovs_m1) |=>
    tx_ph_ff == 6'h00) else $error("Bit period did not end at ratio.");
  shift_empty_a: assert property ((bus_req.rd && bus_req.addr == `USC_ADDR_TXCTL) |=>
    rdata_ff[`USC_TX_EMPTY] == $past(!tx_busy)) else $error("Shift empty reads wrong.");
  overrun_hold_a: assert property ((overrun_error_flag_ff && rxctl_ff[`USC_RX_CONTINUOUS_RECEIVE_ENABLE]) |=> overrun_error_flag_ff)
    else $error("Overrun cleared while receive enabled.");
  framing_error_flag_hold_a: assert property ((framing_error_flag_ff && !rx_done) |=> framing_error_flag_ff)
    else $error("Framing error cleared without a new character.");
endmodule : usc_serial_port

/* File: usc_peer.sv */
// Serial peripheral model: async terminal and sync clock source.
`timescale 1ns/10ps
module usc_peer (
  input wire logic ref_clk, // Bench clock that times every bit.
  input wire logic ck_line, // Transmit or clock wire level.
  input wire logic dt_line, // Receive or data wire level.
  output logic ck_o, // Clock drive value.
  output logic ck_oe, // Clock drive enable.
  output logic dt_o, // Data drive value.
  output logic dt_oe // Data drive enable.
);
  // Both wires are released at start; the bench pulls them high.
  initial begin
    ck_o = 1'b1;
    ck_oe = 1'b0;
    dt_o = 1'b1;
    dt_oe = 1'b0;
  end
  // Async frame into the block; a low stop bit provokes a framing fault.
  task automatic send_async(input logic [7:0] d, input int bt, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      dt_oe <= 1'b1;
      dt_o <= f[i];
      repeat (bt - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    dt_oe <= 1'b0;
  endtask : send_async
  // Async frame out of the block, sampled mid-bit; returns stop and data.
  task automatic recv_async(output logic [8:0] f, input int bt);
    int n;
    n = 0;
    while (ck_line !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (bt / 2) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bt) @(posedge ref_clk);
      f[i] = ck_line;
    end
    f = {f[8], f[7:0]};
  endtask : recv_async
  // clock from outside: 800 ns period, data changes as the clock falls.
  task automatic send_sync(input logic [7:0] d);
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      ck_oe <= 1'b1;
      ck_o <= 1'b0;
      dt_oe <= 1'b1;
      dt_o <= d[i];
      repeat (4) @(posedge ref_clk);
      ck_o <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    ck_oe <= 1'b0;
    dt_oe <= 1'b0;
  endtask : send_sync
  // Sync receive: take the data wire at each rising edge of the clock wire.
  task automatic recv_sync(output logic [7:0] d);
    logic prev;
    int k;
    int n;
    prev = ck_line;
    k = 0;
    n = 0;
    while (k < 8 && n < 3000) begin
      @(posedge ref_clk);
      n++;
      if (ck_line === 1'b1 && prev === 1'b0) begin
        d[k] = dt_line;
        k++;
      end
      prev = ck_line;
    end
  endtask : recv_sync
endmodule : usc_peer

/* File: usart_mode_and_status_control_tb.sv */
// Self-checking bench for the serial port mode and status block.
`timescale 1ns/10ps
`include "usc_consts.svh"
module usart_mode_and_status_control_tb;
  import usc_pkg::*;
  logic ref_clk;
  logic rst;
  usc_bus_req_t bus_req;
  logic [7:0] rdata;
  logic irq;
  logic txck_o, txck_oe, dt_o, dt_oe, pk_o, pk_oe, pd_o, pd_oe;
  logic txck_w, dt_w;
  int errors = 0;
  int comparisons = 0;
  // Pins have pull-ups: a released wire reads high.
  assign txck_w = txck_oe ? txck_o : (pk_oe ? pk_o : 1'b1);
  assign dt_w = dt_oe ? dt_o : (pd_oe ? pd_o : 1'b1);
  usc_serial_port dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .irq(irq), .transmit_clock_pin_i(txck_w), .transmit_clock_pin_o(txck_o),
    .transmit_clock_pin_oe(txck_oe), .receive_data_pin_i(dt_w), .receive_data_pin_o(dt_o),
    .receive_data_pin_oe(dt_oe));
  usc_peer peer (.ref_clk(ref_clk), .ck_line(txck_w), .dt_line(dt_w), .ck_o(pk_o),
    .ck_oe(pk_oe), .dt_o(pd_o), .dt_oe(pd_oe));
  // Clock of 100 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  // One-cycle read; data is taken in the following cycle.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 chk(what, {1'b0, rdata}, {1'b0, exp});
  endtask : rdchk
  // Reset values, an unmapped address and read-only bits.
  task automatic t_reset();
    rdchk(`USC_ADDR_TXCTL, 8'h02, "tx ctl reset");
    rdchk(`USC_ADDR_RXCTL, 8'h00, "rx ctl reset");
    rdchk(`USC_ADDR_PORTDIR, 8'hff, "dir reset");
    wr(8'h55, 8'hff);
    rdchk(8'h55, 8'h00, "unmapped");
    wr(`USC_ADDR_TXCTL, 8'h0a);
    rdchk(`USC_ADDR_TXCTL, 8'h02, "read only bits");
    $display("test reset done");
  endtask : t_reset
  // Pin hand-over needs port enable and both direction bits.
  task automatic t_pins();
    logic [7:0] dirs [4] = '{8'hff, 8'hff, 8'hbf, 8'h7f};
    logic [7:0] ens [4] = '{8'h00, 8'h80, 8'h80, 8'h80};
    logic exp [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    wr(`USC_ADDR_TXCTL, 8'h24);
    for (int i = 0; i < 4; i++) begin
      wr(`USC_ADDR_PORTDIR, dirs[i]);
      wr(`USC_ADDR_RXCTL, ens[i]);
      repeat (3) @(posedge ref_clk);
      chk("tx pin enable", txck_oe, exp[i]);
      chk("data pin enable", dt_oe, 1'b0);
    end
    wr(`USC_ADDR_PORTDIR, 8'hff);
    $display("test pins done");
  endtask : t_pins
  // Full duplex async at both baud multipliers.
  task automatic t_async();
    logic [8:0] f;
    int bt;
    for (int h = 1; h >= 0; h--) begin
      bt = h ? 16 : 64;
      wr(`USC_ADDR_TXCTL, h ? 8'h24 : 8'h20);
      wr(`USC_ADDR_RXCTL, 8'h90);
      fork
        peer.recv_async(f, bt);
        peer.send_async(8'h5a, bt, 1'b1);
        begin
          wr(`USC_ADDR_TXBUF, 8'ha5);
          repeat (8) @(posedge ref_clk);
          rdchk(`USC_ADDR_TXCTL, h ? 8'h24 : 8'h20, "shift busy");
        end
      join
      chk("async frame", f, 9'h1a5);
      repeat (4 * bt) @(posedge ref_clk);
      rdchk(`USC_ADDR_RXBUF, 8'h5a, "async rx");
      rdchk(`USC_ADDR_TXCTL, h ? 8'h26 : 8'h22, "shift empty");
    end
    $display("test async done");
  endtask : t_async
  // Framing fault renewal and overrun persistence.
  task automatic t_errors();
    wr(`USC_ADDR_TXCTL, 8'h24);
    peer.send_async(8'h33, 16, 1'b0);
    repeat (4) @(posedge ref_clk);
    rdchk(`USC_ADDR_RXCTL, 8'h94, "framing set");
    rdchk(`USC_ADDR_RXBUF, 8'h33, "framed char");
    rdchk(`USC_ADDR_RXCTL, 8'h94, "framing held");
    peer.send_async(8'h44, 16, 1'b1);
    repeat (4) @(posedge ref_clk);
    rdchk(`USC_ADDR_RXCTL, 8'h90, "framing cleared");
    rdchk(`USC_ADDR_RXBUF, 8'h44, "good char");
    peer.send_async(8'h11, 16, 1'b1);
    peer.send_async(8'h22, 16, 1'b1);
    repeat (4) @(posedge ref_clk);
    rdchk(`USC_ADDR_RXCTL, 8'h92, "overrun set");
    rdchk(`USC_ADDR_RXBUF, 8'h11, "kept char");
    rdchk(`USC_ADDR_RXCTL, 8'h92, "overrun held");
    wr(`USC_ADDR_RXCTL, 8'h80);
    rdchk(`USC_ADDR_RXCTL, 8'h80, "overrun cleared");
    wr(`USC_ADDR_RXCTL, 8'h90);
    $display("test errors done");
  endtask : t_errors
  // Sticky status, mask and write-one-to-clear.
  task automatic t_irq();
    wr(`USC_ADDR_INTSTAT, 8'h0f);
    wr(`USC_ADDR_INTMASK, 8'h00);
    peer.send_async(8'h66, 16, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk("masked irq", irq, 1'b0);
    wr(`USC_ADDR_INTSTAT, 8'h00);
    rdchk(`USC_ADDR_INTSTAT, 8'h01, "sticky status");
    wr(`USC_ADDR_INTMASK, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("irq raised", irq, 1'b1);
    rdchk(`USC_ADDR_RXBUF, 8'h66, "irq char");
    wr(`USC_ADDR_INTSTAT, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", irq, 1'b0);
    $display("test irq done");
  endtask : t_irq
  // Sync master drives clock and data one way.
  task automatic t_master();
    logic [7:0] d;
    wr(`USC_ADDR_RXCTL, 8'h80);
    wr(`USC_ADDR_BAUD, 8'h01);
    wr(`USC_ADDR_TXCTL, 8'hb0);
    fork
      peer.recv_sync(d);
      begin
        wr(`USC_ADDR_TXBUF, 8'h3c);
        repeat (12) @(posedge ref_clk);
        #1 chk("master data drive", dt_oe, 1'b1);
        chk("master clock drive", txck_oe, 1'b1);
      end
    join
    chk("sync master data", d, 8'h3c);
    repeat (8) @(posedge ref_clk);
    rdchk(`USC_ADDR_TXCTL, 8'hb2, "master idle");
    $display("test master done");
  endtask : t_master
  // Sync slave shifts on the received clock.
  task automatic t_slave();
    wr(`USC_ADDR_TXCTL, 8'h10);
    // Let the released clock wire settle high before the receiver listens.
    repeat (6) @(posedge ref_clk);
    wr(`USC_ADDR_RXCTL, 8'h90);
    fork
      peer.send_sync(8'hc5);
      begin
        repeat (20) @(posedge ref_clk);
        #1 chk("slave clock drive", txck_oe, 1'b0);
        chk("slave data drive", dt_oe, 1'b0);
      end
    join
    repeat (10) @(posedge ref_clk);
    rdchk(`USC_ADDR_RXBUF, 8'hc5, "sync slave data");
    $display("test slave done");
  endtask : t_slave
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #3000000;
    errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
  // Main sequence after five reset cycles.
  initial begin
    rst = 1'b1;
    bus_req = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_pins();
    t_async();
    t_errors();
    t_irq();
    t_master();
    t_slave();
    tally_and_finish();
  end
endmodule : usart_mode_and_status_control_tb
